// ===== motor_pkg.sv
// Purpose: Shared constants and carriers for the motor starter stop interlock.
// Assumes: 32-bit APB register access, byte addresses, one word per register.
// Notes:   Field layouts follow the packed struct order, most significant first.
package motor_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [7:0] OFF_CFG    = 8'h00;
  localparam logic [7:0] OFF_RATED  = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_CTRL   = 8'h0C;
  localparam int unsigned CTRL_APPLY_POL = 0;   // Write 1 re-reads sensor polarity
  localparam logic [15:0] RATED_RESET    = 16'h0000;
  localparam int unsigned UL_SHIFT       = 2;   // Quarter of rated current

  // ************************************************************
  // Setting encodings
  // ************************************************************
  localparam logic [2:0] STOP_NONE  = 3'h1;
  localparam logic [2:0] STOP_CFG2  = 3'h2;
  localparam logic [2:0] STOP_CFG3  = 3'h3;
  localparam logic [2:0] STOP_CFG4  = 3'h4;
  localparam logic [1:0] UL_OFF     = 2'h0;
  localparam logic [1:0] UL_WARN    = 2'h1;
  localparam logic [1:0] UL_TRIP    = 2'h2;

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic [2:0] stop_config_select;
    logic       phase_order_select;
    logic [1:0] underload_response;
    logic       quickstop_enable;
    logic       sensor_a_polarity;
    logic       sensor_b_polarity;
  } cfg_t;
  localparam int unsigned CFG_W = $bits(cfg_t);
  localparam cfg_t CFG_RESET = '{stop_config_select: STOP_NONE, phase_order_select: 1'b0,
                                 underload_response: UL_OFF, quickstop_enable: 1'b0,
                                 sensor_a_polarity: 1'b0, sensor_b_polarity: 1'b0};

  typedef struct packed {
    logic auto_mode;
    logic underload_trip;
    logic underload_flag;
    logic stop_rev;
    logic stop_fwd;
    logic pol_b_active;
    logic pol_a_active;
    logic run_rev;
    logic run_fwd;
  } status_t;
  localparam int unsigned STATUS_W = $bits(status_t);

  // Fieldbus run command
  typedef struct packed {
    logic run_rev;
    logic run_fwd;
  } bus_cmd_t;

  // Local key switch and direction selector
  typedef struct packed {
    logic auto_mode;
    logic reset_pos;
    logic dir_forward;
    logic dir_reverse;
  } key_t;

  // Motor state, one-hot
  typedef enum logic [2:0] {
    ST_STOP = 3'b001,
    ST_FWD  = 3'b010,
    ST_REV  = 3'b100
  } motor_state_t;

endpackage

// ===== motor_stop_interlock.sv
// Purpose: Sensor stop interlock, restart logic, phase order and underload gate.
// Assumes: All inputs synchronous to clk_i; phase currents come in rated units.
// Notes:   rst_i stands for a power cycle; settings return to factory values.
//
// Functional notes
// [R1] Stop setting 1: sensors have no stopping function in any mode.
// [R2] Direct, setting 2: either sensor stops; manual restart on key reset rising edge.
// [R3] Direct, setting 3: sensor A stops only in automatic mode.
// [R4] Direct, setting 4: sensor A stops always; manual restart key reset, A inactive.
// [R5] Reversing, setting 2: sensor A stops both directions, automatic only.
// [R6] Reversing, setting 3: automatic, A stops forward, B stops reverse.
// [R7] Reversing, setting 4: A stops forward, B stops reverse, both modes.
// [R8] Forward stop: manual restart needs key reset with A idle, or reverse detour.
// [R9] Reverse stop: manual restart needs key reset with B idle, or forward detour.
// [R10] Automatic: restart only after the fieldbus run command changes.
// [R11] Phase order setting: 0 gives U-V-W, 1 gives U-W-V; default 0.
// [R12] Swap acts only at power output; logic and indicators stay forward.
// [R13] Direct starter ignores the phase order setting.
// [R14] Underload response: 0 off, 1 warning, 2 error with shutdown; default 0.
// [R15] Enabled underload flags any phase below a quarter of rated current.
// [R16] Quick-stop bus bit acts only when quick-stop enable is set; default 0.
// [R17] Quick-stop enabled: bit 0 obeys sensors, bit 1 ignores them.
// [R18] Quick-stop disabled: bus bit is disregarded entirely.
// [R19] Per-sensor polarity; 1 inverts; change applies only after a power cycle; the code loads it on a CTRL apply write, reset gives 0.
// [R20] Sensor stop drops run the next cycle and holds until restart allowed.
// [R21] Settings take factory defaults at reset and feed internal state.
`timescale 1ns/10ps
`default_nettype none

module motor_stop_interlock #(
  parameter int unsigned REVERSING = 1,   // 0 direct starter, 1 reversing starter
  parameter int unsigned CUR_W     = 16,  // Phase current width
  parameter int unsigned ADDR_W    = 8
) (
  // Clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  // APB slave
  input  wire logic                    psel_i,
  input  wire logic                    penable_i,
  input  wire logic                    pwrite_i,
  input  wire logic [ADDR_W-1:0]       paddr_i,
  input  wire logic [31:0]             pwdata_i,
  output logic [31:0]                  prdata_o,
  output logic                         pready_o,
  output logic                         pslverr_o,
  // Fieldbus and local operator inputs
  input  wire motor_pkg::bus_cmd_t     bus_cmd_i,
  input  wire logic                    quickstop_bus_bit_i,
  input  wire motor_pkg::key_t         key_i,
  // Sensors and phase currents
  input  wire logic                    sensor_in_a_i,
  input  wire logic                    sensor_in_b_i,
  input  wire logic [3*CUR_W-1:0]      phase_cur_i,
  // Power stage and indicators
  output logic                         power_run_o,
  output logic                         power_uwv_o,
  output logic                         ind_fwd_o,
  output logic                         ind_rev_o,
  output logic                         underload_o,
  output logic                         fault_o
);
  import motor_pkg::*;

  // ************************************************************
  // Elaboration checks
  // ************************************************************
  if (REVERSING > 1) begin : g_bad_variant
    $error("REVERSING must be 0 or 1");
  end
  if (CUR_W < 2 || CUR_W > 30) begin : g_bad_cur
    $error("CUR_W must lie between 2 and 30");
  end
  if (ADDR_W < 8) begin : g_bad_addr
    $error("ADDR_W must be at least 8");
  end

  localparam logic REV_EN = (REVERSING == 1);

  // ************************************************************
  // Registers
  // ************************************************************
  cfg_t              cfg_reg;
  logic [CUR_W-1:0]  rated_reg;
  logic              pol_a_reg;
  logic              pol_b_reg;
  motor_state_t      state_reg;
  motor_state_t      state_next;
  logic              stop_fwd_reg;
  logic              stop_rev_reg;
  logic              stop_fwd_next;
  logic              stop_rev_next;
  bus_cmd_t          bus_prev_reg;
  logic              key_reset_prev_reg;
  logic              ul_flag_reg;
  logic              ul_trip_reg;
  logic              power_run_reg;
  logic              power_uwv_reg;
  logic [31:0]       prdata_reg;

  // ************************************************************
  // APB decode
  // ************************************************************
  wire logic [7:0] addr_lo  = paddr_i[7:0];
  wire logic       hi_zero  = (paddr_i >> 8) == '0;
  wire logic       hit_cfg  = hi_zero && (addr_lo == OFF_CFG);
  wire logic       hit_rat  = hi_zero && (addr_lo == OFF_RATED);
  wire logic       hit_sts  = hi_zero && (addr_lo == OFF_STATUS);
  wire logic       hit_ctl  = hi_zero && (addr_lo == OFF_CTRL);
  wire logic       mapped   = hit_cfg || hit_rat || hit_sts || hit_ctl;
  wire logic       access   = psel_i && penable_i;
  wire logic       wr_ok    = access && pwrite_i && mapped;
  wire logic       apply_pol = wr_ok && hit_ctl && pwdata_i[CTRL_APPLY_POL];

  // No wait states; unmapped addresses error in the access phase
  assign pready_o  = 1'b1;
  assign pslverr_o = access && !mapped;
  assign prdata_o  = prdata_reg;

  status_t   status;
  logic [31:0] rd_mux;

  // Read selection; write-only CTRL reads as zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_cfg) begin
      rd_mux[CFG_W-1:0] = cfg_reg;
    end else if (hit_rat) begin
      rd_mux[CUR_W-1:0] = rated_reg;
    end else if (hit_sts) begin
      rd_mux[STATUS_W-1:0] = status;
    end
  end

  // Read data captured in the setup phase so it comes from a flop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prdata_reg <= 32'h0000_0000;
    end else if (psel_i && !penable_i) begin
      prdata_reg <= rd_mux;
    end
  end

  // Setting registers; factory values on reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_reg   <= CFG_RESET;                          // [R21] [R1] [R11] [R14] [R16]
      rated_reg <= CUR_W'(RATED_RESET);
    end else if (wr_ok && hit_cfg) begin
      cfg_reg   <= cfg_t'(pwdata_i[CFG_W-1:0]);
    end else if (wr_ok && hit_rat) begin
      rated_reg <= pwdata_i[CUR_W-1:0];
    end
  end

  // Polarity holds until reset or a CTRL apply write; software change waits for apply
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pol_a_reg <= CFG_RESET.sensor_a_polarity;        // [R19] [R21]
      pol_b_reg <= CFG_RESET.sensor_b_polarity;
    end else if (apply_pol) begin
      pol_a_reg <= cfg_reg.sensor_a_polarity;          // [R19]
      pol_b_reg <= cfg_reg.sensor_b_polarity;
    end
  end

  // ************************************************************
  // Sensor qualification
  // ************************************************************
  // Polarity, then quick-stop gate
  wire logic sa_q      = sensor_in_a_i ^ pol_a_reg;               // [R19]
  wire logic sb_q      = sensor_in_b_i ^ pol_b_reg;               // [R19]
  wire logic qs_ignore = cfg_reg.quickstop_enable && quickstop_bus_bit_i; // [R16] [R17] [R18]
  wire logic live      = !qs_ignore;
  wire logic sa_live   = live && sa_q;
  wire logic sb_live   = live && sb_q;

  wire logic [2:0] sc   = cfg_reg.stop_config_select;
  wire logic is2        = (sc == STOP_CFG2);
  wire logic is3        = (sc == STOP_CFG3);
  wire logic is4        = (sc == STOP_CFG4);
  wire logic auto_m     = key_i.auto_mode;

  // Whether sensor stops apply in the present mode; setting 1 never applies
  wire logic applies_auto   = is2 || is3 || is4;                              // [R1]
  wire logic applies_manual = REV_EN ? is4 : (is2 || is4);                    // [R3] [R5] [R6]
  wire logic applies        = auto_m ? applies_auto : applies_manual;

  // Stop conditions per direction
  wire logic cond_fwd_dir = REV_EN ? sa_live                                  // [R5] [R6] [R7]
                                   : (is2 ? (sa_live || sb_live) : sa_live);  // [R2] [R3] [R4]
  wire logic cond_rev_dir = REV_EN && (is2 ? sa_live : sb_live);              // [R5] [R6] [R7]
  wire logic kill_fwd     = applies && cond_fwd_dir;
  wire logic kill_rev     = applies && cond_rev_dir;

  // ************************************************************
  // Restart conditions
  // ************************************************************
  wire logic bus_change = (bus_cmd_i != bus_prev_reg);
  wire logic key_rise   = key_i.reset_pos && !key_reset_prev_reg;

  // Manual release of a forward stop
  wire logic man_clr_fwd = REV_EN ? ((key_i.reset_pos && !sa_q) || key_i.dir_reverse) // [R8]
                                  : (is2 ? key_rise                                    // [R2]
                                         : (key_i.reset_pos && !sa_q));                // [R4]
  // Manual release of a reverse stop
  wire logic man_clr_rev = (key_i.reset_pos && !sb_q) || key_i.dir_forward;            // [R9]
  wire logic clr_fwd     = auto_m ? bus_change : man_clr_fwd;                          // [R10]
  wire logic clr_rev     = auto_m ? bus_change : man_clr_rev;                          // [R10]

  // ************************************************************
  // Underload monitor
  // ************************************************************
  wire logic ul_en    = (cfg_reg.underload_response == UL_WARN) ||
                        (cfg_reg.underload_response == UL_TRIP);             // [R14]
  wire logic running  = (state_reg != ST_STOP);
  logic [2:0] below;

  // One comparator per phase: 4 * current below rated
  for (genvar p = 0; p < 3; p++) begin : g_phase
    wire logic [CUR_W+UL_SHIFT-1:0] scaled = {phase_cur_i[p*CUR_W +: CUR_W], {UL_SHIFT{1'b0}}};
    assign below[p] = scaled < {{UL_SHIFT{1'b0}}, rated_reg};                // [R15]
  end

  wire logic ul_now   = running && ul_en && (|below);                        // [R15]
  wire logic ul_set   = ul_now && (cfg_reg.underload_response == UL_TRIP);  // [R14]

  // ************************************************************
  // Run request and state
  // ************************************************************
  wire logic man_ok    = !auto_m && !key_i.reset_pos;
  wire logic req_f     = auto_m ? bus_cmd_i.run_fwd : (man_ok && key_i.dir_forward);
  wire logic req_r_raw = auto_m ? bus_cmd_i.run_rev : (man_ok && key_i.dir_reverse);
  // Conflicting requests are treated as stop on the reversing variant
  wire logic want_fwd  = req_f && !(REV_EN && req_r_raw);
  wire logic want_rev  = REV_EN && req_r_raw && !req_f;
  wire logic trip_any  = ul_trip_reg || ul_set;
  wire logic ok_fwd    = want_fwd && !(stop_fwd_reg && applies) && !kill_fwd && !trip_any;
  wire logic ok_rev    = want_rev && !(stop_rev_reg && applies) && !kill_rev && !trip_any;

  // Next motor state; a qualified stop drops run at the next edge
  always_comb begin
    case (state_reg)
      ST_FWD: begin
        state_next = ok_fwd ? ST_FWD : (ok_rev ? ST_REV : ST_STOP); // [R20]
      end
      ST_REV: begin
        state_next = ok_rev ? ST_REV : (ok_fwd ? ST_FWD : ST_STOP); // [R20]
      end
      default: begin
        state_next = ok_fwd ? ST_FWD : (ok_rev ? ST_REV : ST_STOP);
      end
    endcase
  end

  // Stop latches; a new stop wins over a release in the same cycle
  always_comb begin
    stop_fwd_next = stop_fwd_reg;
    stop_rev_next = stop_rev_reg;
    if (clr_fwd) begin
      stop_fwd_next = 1'b0;
    end
    if (clr_rev) begin
      stop_rev_next = 1'b0;
    end
    if (state_reg == ST_FWD && kill_fwd) begin
      stop_fwd_next = 1'b1;                                         // [R20]
    end
    if (state_reg == ST_REV && kill_rev) begin
      stop_rev_next = 1'b1;                                         // [R20]
    end
  end

  // Power output order follows swapped field only on the reversing variant
  wire logic uwv_next = REV_EN && (cfg_reg.phase_order_select ^ (state_next == ST_REV)); // [R11] [R12] [R13]

  // Motor state and output registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg     <= ST_STOP;
      stop_fwd_reg  <= 1'b0;
      stop_rev_reg  <= 1'b0;
      power_run_reg <= 1'b0;
      power_uwv_reg <= 1'b0;
    end else begin
      state_reg     <= state_next;
      stop_fwd_reg  <= stop_fwd_next;
      stop_rev_reg  <= stop_rev_next;
      power_run_reg <= (state_next != ST_STOP);
      power_uwv_reg <= uwv_next;
    end
  end

  // Edge history; reset command value blocks a spurious change at start
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_prev_reg       <= '0;
      key_reset_prev_reg <= 1'b0;
    end else begin
      bus_prev_reg       <= bus_cmd_i;
      key_reset_prev_reg <= key_i.reset_pos;
    end
  end

  // Underload flag follows the monitor; trip latch releases on key reset edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ul_flag_reg <= 1'b0;
      ul_trip_reg <= 1'b0;
    end else begin
      ul_flag_reg <= ul_now;                                        // [R15]
      ul_trip_reg <= ul_set || (ul_trip_reg && !key_rise);          // [R14]
    end
  end

  // ************************************************************
  // Outputs and status
  // ************************************************************
  // Indicators keep the logical direction regardless of swap
  assign ind_fwd_o   = (state_reg == ST_FWD);                       // [R12]
  assign ind_rev_o   = (state_reg == ST_REV);
  assign power_run_o = power_run_reg;
  assign power_uwv_o = power_uwv_reg;
  assign underload_o = ul_flag_reg;
  assign fault_o     = ul_trip_reg;

  assign status = '{auto_mode: auto_m, underload_trip: ul_trip_reg,
                    underload_flag: ul_flag_reg, stop_rev: stop_rev_reg,
                    stop_fwd: stop_fwd_reg, pol_b_active: pol_b_reg,
                    pol_a_active: pol_a_reg, run_rev: ind_rev_o, run_fwd: ind_fwd_o};

  // ************************************************************
  // Assertions
  // ************************************************************
  sequence s_fwd_stop;
    (state_reg == ST_FWD) && kill_fwd;
  endsequence

  sequence s_latched_auto;
    auto_m && stop_fwd_reg && (bus_cmd_i == bus_prev_reg) && applies;
  endsequence

  AST_CFG1_NO_STOP: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
    (sc == STOP_NONE) |-> !kill_fwd && !kill_rev)
    else $error("Setting 1 produced a sensor stop");

  AST_STOP_NEXT: assert property (@(posedge clk_i) disable iff (rst_i) // [R20]
    s_fwd_stop |=> (state_reg != ST_FWD) && stop_fwd_reg && !ind_fwd_o)
    else $error("Forward run not dropped after sensor stop");

  AST_AUTO_HOLD: assert property (@(posedge clk_i) disable iff (rst_i) // [R10]
    s_latched_auto |=> stop_fwd_reg && (state_reg != ST_FWD))
    else $error("Automatic restart without command change");

  AST_QS_IGNORE: assert property (@(posedge clk_i) disable iff (rst_i) // [R17]
    (cfg_reg.quickstop_enable && quickstop_bus_bit_i) |-> !kill_fwd && !kill_rev)
    else $error("Sensors obeyed while quick-stop bit set");

  AST_QS_OFF: assert property (@(posedge clk_i) disable iff (rst_i) // [R18]
    (!cfg_reg.quickstop_enable && is4 && sa_q) |-> kill_fwd)
    else $error("Quick-stop bit acted while disabled");

  AST_DIRECT_CFG3_MAN: assert property (@(posedge clk_i) disable iff (rst_i) // [R3]
    (!REV_EN && is3 && !auto_m) |-> !kill_fwd)
    else $error("Setting 3 stopped the direct starter in manual mode");

  AST_PHASE_FWD: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
    (REV_EN && state_next == ST_FWD) ##1 1'b1 |->
      power_uwv_o == $past(cfg_reg.phase_order_select) && ind_fwd_o)
    else $error("Power phase order does not follow the setting");

  AST_DIRECT_NO_SWAP: assert property (@(posedge clk_i) disable iff (rst_i) // [R13]
    !REV_EN |-> !power_uwv_o)
    else $error("Direct starter swapped phases");

  AST_UL_TRIP: assert property (@(posedge clk_i) disable iff (rst_i) // [R14]
    ul_set |=> (state_reg == ST_STOP) && fault_o && underload_o)
    else $error("Underload error did not shut down");

  AST_REV_DETOUR: assert property (@(posedge clk_i) disable iff (rst_i) // [R8]
    (REV_EN && is4 && !auto_m && stop_fwd_reg && key_i.dir_reverse &&
     !((state_reg == ST_FWD) && kill_fwd)) |=> !stop_fwd_reg)
    else $error("Reverse selection did not release forward stop");

  AST_KEY_EDGE: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
    (!REV_EN && is2 && !auto_m && stop_fwd_reg && key_i.reset_pos &&
     key_reset_prev_reg) |=> stop_fwd_reg)
    else $error("Held key reset released a stop without an edge");

endmodule

`default_nettype wire

// ===== motor_far_side.sv
// Purpose: Far-side model: head-end run command, quick-stop bit, key and sensors.
// Assumes: The bench posts requests; the model moves its lines just after clk_i.
// Notes:   Plain levels; it copies the bench requests and has no fault mode.
`timescale 1ns/10ps
`default_nettype none
module motor_far_side (
  // Clock
  input  wire logic                clk_i,
  // Requests from the bench
  input  wire motor_pkg::bus_cmd_t cmd_req_i,
  input  wire motor_pkg::key_t     key_req_i,
  input  wire logic                qs_req_i,
  input  wire logic [1:0]          sens_req_i,
  // Toward the block
  output var motor_pkg::bus_cmd_t  bus_cmd_o,
  output var motor_pkg::key_t      key_o,
  output logic                     qs_bit_o,
  output logic                     sensor_a_o,
  output logic                     sensor_b_o
);
  import motor_pkg::*;
  // ******************************
  // Line drivers
  // ******************************
  // Known levels before the first edge
  initial begin
    bus_cmd_o = '0;
    key_o = '0;
    qs_bit_o = 1'b0;
    sensor_a_o = 1'b0;
    sensor_b_o = 1'b0;
  end
  // Each request reaches its line at the next clk_i edge
  always @(posedge clk_i) begin
    bus_cmd_o  <= cmd_req_i;
    qs_bit_o   <= qs_req_i;
    key_o      <= key_req_i;
    sensor_a_o <= sens_req_i[0];
    sensor_b_o <= sens_req_i[1];
  end
endmodule
`default_nettype wire

// ===== test_motor_stop_interlock.sv
// Purpose: Self-checking bench for the motor stop interlock.
// Assumes: Both starter variants, 125 MHz clock, APB slave answering on pready.
// Notes:   Each scenario after t_defaults resets, configures over APB and judges the outputs.
`timescale 1ns/10ps
`default_nettype none
module test_motor_stop_interlock;
  import motor_pkg::*;
  logic        clk_i, rst_i, psel, penable, pwrite, pslverr, pready, qs, qs_req, err;
  logic        run, uwv, ifwd, irev, ul, flt, sa, sb, run_d, uwv_d;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [47:0] cur;
  logic [1:0]  sens_req;
  bus_cmd_t    cmd, cmd_req;
  key_t        key, key_req;
  int          mismatches, n_checks;
  // ******************************
  // Clock, block and far side
  // ******************************
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  motor_stop_interlock u_dut (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .bus_cmd_i(cmd),
    .quickstop_bus_bit_i(qs), .key_i(key), .sensor_in_a_i(sa), .sensor_in_b_i(sb),
    .phase_cur_i(cur), .power_run_o(run), .power_uwv_o(uwv), .ind_fwd_o(ifwd),
    .ind_rev_o(irev), .underload_o(ul), .fault_o(flt));
  motor_far_side u_far (.clk_i(clk_i), .cmd_req_i(cmd_req), .key_req_i(key_req),
    .qs_req_i(qs_req), .sens_req_i(sens_req), .bus_cmd_o(cmd), .key_o(key),
    .qs_bit_o(qs), .sensor_a_o(sa), .sensor_b_o(sb));
  motor_stop_interlock #(.REVERSING(0)) u_dut_direct (.clk_i(clk_i), .rst_i(rst_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(), .pready_o(), .pslverr_o(), .bus_cmd_i(cmd),
    .quickstop_bus_bit_i(qs), .key_i(key), .sensor_in_a_i(sa), .sensor_in_b_i(sb),
    .phase_cur_i(cur), .power_run_o(run_d), .power_uwv_o(uwv_d), .ind_fwd_o(),
    .ind_rev_o(), .underload_o(), .fault_o());
  // ******************************
  // Shared tasks
  // ******************************
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // One transfer; the idle edge first keeps psel from two writes in one step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      mismatches++;
      summarize();
    end
  endtask
  task automatic cfg(input logic [2:0] st, input logic ph, input logic [1:0] u, input logic q);
    apb(1'b1, OFF_CFG, {23'h0, st, ph, u, q, 2'h0});
  endtask
  task automatic drv(input bus_cmd_t c, input key_t k, input logic q, input logic [1:0] s);
    @(posedge clk_i);
    cmd_req <= c;
    key_req <= k;
    qs_req <= q;
    sens_req <= s;
  endtask
  // Outputs settle well inside eight cycles, far side included
  task automatic run_is(input logic exp);
    repeat (8) @(posedge clk_i);
    chk("power_run", {31'h0, exp}, {31'h0, run});
  endtask
  task automatic do_reset(input int n);
    @(posedge clk_i);
    rst_i <= 1'b1;
    drv('0, '0, 1'b0, 2'h0);
    repeat (n) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask
  // ******************************
  // Scenarios
  // ******************************
  task automatic t_defaults();
    apb(1'b0, OFF_CFG, 32'h0);
    chk("cfg_reset", 32'h0000_0040, rd);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, err});
    drv(2'h1, 4'h8, 1'b0, 2'h3);
    run_is(1'b1);
    chk("order_default", 32'h0, {31'h0, uwv});
  endtask
  task automatic t_auto_stop();
    do_reset(2);
    cfg(STOP_CFG2, 1'b0, UL_OFF, 1'b0);
    drv(2'h1, 4'h8, 1'b0, 2'h0);
    run_is(1'b1);
    drv(2'h1, 4'h8, 1'b0, 2'h1);
    run_is(1'b0);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("stop_fwd", 32'h1, {31'h0, rd[4]});
    drv(2'h1, 4'h8, 1'b0, 2'h0);
    run_is(1'b0);
    drv(2'h0, 4'h8, 1'b0, 2'h0);
    drv(2'h1, 4'h8, 1'b0, 2'h0);
    run_is(1'b1);
    drv(2'h2, 4'h8, 1'b0, 2'h1);
    run_is(1'b0);
  endtask
  task automatic t_quick();
    do_reset(2);
    cfg(STOP_CFG2, 1'b0, UL_OFF, 1'b1);
    drv(2'h1, 4'h8, 1'b1, 2'h1);
    run_is(1'b1);
    drv(2'h1, 4'h8, 1'b0, 2'h1);
    run_is(1'b0);
    do_reset(2);
    cfg(STOP_CFG2, 1'b0, UL_OFF, 1'b0);
    drv(2'h1, 4'h8, 1'b1, 2'h1);
    run_is(1'b0);
  endtask
  task automatic t_phase();
    do_reset(2);
    cfg(STOP_NONE, 1'b1, UL_OFF, 1'b0);
    drv(2'h1, 4'h8, 1'b0, 2'h0);
    run_is(1'b1);
    chk("uwv_fwd_rev", 32'h6, {29'h0, uwv, ifwd, irev});
    chk("direct_uwv", 32'h2, {30'h0, run_d, uwv_d});
    cfg(STOP_CFG3, 1'b1, UL_OFF, 1'b0);
    drv(2'h2, 4'h8, 1'b0, 2'h1);
    run_is(1'b1);
    drv(2'h2, 4'h8, 1'b0, 2'h2);
    run_is(1'b0);
  endtask
  task automatic t_manual4();
    do_reset(2);
    cfg(STOP_CFG4, 1'b0, UL_OFF, 1'b0);
    drv(2'h0, 4'h2, 1'b0, 2'h0);
    run_is(1'b1);
    drv(2'h0, 4'h2, 1'b0, 2'h1);
    run_is(1'b0);
    drv(2'h0, 4'h2, 1'b0, 2'h0);
    run_is(1'b0);
    chk("direct_hold", 32'h0, {31'h0, run_d});
    drv(2'h0, 4'h1, 1'b0, 2'h0);
    run_is(1'b1);
    chk("ind_rev", 32'h1, {31'h0, irev});
    drv(2'h0, 4'h1, 1'b0, 2'h2);
    run_is(1'b0);
    drv(2'h0, 4'h5, 1'b0, 2'h0);
    drv(2'h0, 4'h1, 1'b0, 2'h0);
    run_is(1'b1);
  endtask
  task automatic t_underload();
    do_reset(2);
    apb(1'b1, OFF_RATED, 32'h64);
    cfg(STOP_NONE, 1'b0, UL_WARN, 1'b0);
    drv(2'h1, 4'h8, 1'b0, 2'h0);
    cur <= {16'h0064, 16'h0064, 16'h0019};
    run_is(1'b1);
    chk("underload_edge", 32'h0, {31'h0, ul});
    cur <= {16'h0064, 16'h0064, 16'h0018};
    run_is(1'b1);
    chk("underload_low", 32'h1, {31'h0, ul});
    cfg(STOP_NONE, 1'b0, UL_TRIP, 1'b0);
    run_is(1'b0);
    chk("underload_trip", 32'h1, {31'h0, flt});
  endtask
  task automatic t_polarity();
    do_reset(2);
    apb(1'b1, OFF_CFG, 32'h0000_0082);
    drv(2'h1, 4'h8, 1'b0, 2'h0);
    run_is(1'b1);
    apb(1'b1, OFF_CTRL, 32'h1);
    run_is(1'b0);
  endtask
  task automatic t_direct();
    do_reset(2);
    cfg(STOP_CFG3, 1'b0, UL_OFF, 1'b0);
    drv(2'h0, 4'h2, 1'b0, 2'h3);
    run_is(1'b1);
    chk("direct_run", 32'h1, {31'h0, run_d});
    cfg(STOP_CFG2, 1'b0, UL_OFF, 1'b0);
    run_is(1'b1);
    chk("direct_run", 32'h0, {31'h0, run_d});
  endtask
  // ******************************
  // Main sequence
  // ******************************
  initial begin
    mismatches = 0;
    n_checks = 0;
    rst_i = 1'b1;
    {psel, penable, pwrite, qs_req} = 4'h0;
    {paddr, pwdata, sens_req, cmd_req, key_req} = '0;
    cur = {3{16'h0064}};
    do_reset(10);
    t_defaults();
    t_auto_stop();
    t_quick();
    t_phase();
    t_manual4();
    t_underload();
    t_polarity();
    t_direct();
    summarize();
  end
endmodule
`default_nettype wire
